/* File: rtl/bridge_rect_dev.sv */
// Behaviour
// - off-time starts on disable or trip
// - decay switches MOSFETs per rectifier mode
// - active mode: rectifier off at zero current
// - passive mode: rectifier off at reverse limit
// - disabled mode: no switching in fast decay
// - disabled mode: low side on in slow
// - thermal fault disables all drivers
// - data shifted on serial clock rise
// - host holds strobe high while idle
// - words sent most significant bit first
// - host waits after sleep before clocking
// - outputs enable only after idle-release delay
// - two-bit field selects rectifier mode
// - sleep resets word, off-time top bit set
// - mixed decay: fast first, then slow
`timescale 1ns/1ps
`default_nettype none
module bridge_rect_dev #(
  parameter int IDLE_CYC = bridge_pkg::IDLE_RELEASE_CYC
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  bridge_link_if.dev                         link,
  input  wire logic                          bridge_off_cmd,
  input  wire logic                          current_trip,
  input  wire logic                          zero_current,
  input  wire logic                          reverse_limit,
  input  wire logic                          thermal_fault,
  output logic [bridge_pkg::WORD_W-1:0]      control_word,
  output logic                               drivers_enabled,
  output logic                               off_active,
  output logic                               fast_decay,
  output logic                               sync_rect_on,
  output logic                               low_side_on
);
  localparam int W = bridge_pkg::WORD_W;

  // three-stage pin sample, taken once stages two and three agree; resets to idle levels so no false edge follows
  logic [3:0] s1_reg;
  logic [3:0] s2_reg;
  logic [3:0] s3_reg;
  logic [3:0] pin_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_reg  <= 4'h4;
      s2_reg  <= 4'h4;
      s3_reg  <= 4'h4;
      pin_reg <= 4'h4;
    end else begin
      s1_reg <= {link.sleep_n, link.strobe_n, link.sdata, link.sclk};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < 4; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          pin_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  logic sclk_f;
  logic sdata_f;
  logic strobe_f;
  logic sleep_f;
  logic sclk_next;
  logic strobe_next;
  assign sclk_f      = pin_reg[0];
  assign sdata_f     = pin_reg[1];
  assign strobe_f    = pin_reg[2];
  assign sleep_f     = pin_reg[3];
  assign sclk_next   = (s2_reg[0] == s3_reg[0]) ? s3_reg[0] : sclk_f;
  assign strobe_next = (s2_reg[2] == s3_reg[2]) ? s3_reg[2] : strobe_f;

  logic sclk_rise;
  logic strobe_rise;
  assign sclk_rise   = sclk_next & ~sclk_f;
  assign strobe_rise = strobe_next & ~strobe_f;

  // serial word shift and load
  logic [W-1:0] shift_reg;
  logic [W-1:0] word_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_reg <= bridge_pkg::SLEEP_WORD;
    end else if (!sleep_f) begin
      shift_reg <= bridge_pkg::SLEEP_WORD;
    end else if (sclk_rise && !strobe_f) begin
      // the data pin was settled before the clock edge reached the filter
      shift_reg <= {shift_reg[W-2:0], sdata_f};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      word_reg <= bridge_pkg::SLEEP_WORD;
    end else if (!sleep_f) begin
      word_reg <= bridge_pkg::SLEEP_WORD;
    end else if (strobe_rise) begin
      // a strobe held high by an idle host never loads; partial shifts stay invisible
      word_reg <= shift_reg;
    end
  end

  bridge_pkg::rect_mode_t mode;
  logic [7:0]             off_end;
  logic [7:0]             fast_end;
  assign mode     = bridge_pkg::rect_mode_t'(word_reg[bridge_pkg::RECT_LSB +: 2]);
  assign off_end  = {word_reg[bridge_pkg::OFF_LSB +: bridge_pkg::OFF_W], 3'b111};
  assign fast_end = {1'b0, word_reg[bridge_pkg::FAST_LSB +: bridge_pkg::FAST_W], 3'b111};

  // idle release delay before outputs may drive
  localparam int IW = $clog2(IDLE_CYC + 1);
  logic [IW-1:0] idle_cnt_reg;
  logic          awake;
  assign awake = sleep_f & word_reg[bridge_pkg::IDLE_BIT];
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      idle_cnt_reg <= '0;
    end else if (!awake) begin
      idle_cnt_reg <= '0;
    end else if (idle_cnt_reg != IW'(IDLE_CYC)) begin
      idle_cnt_reg <= idle_cnt_reg + 1'b1;
    end
  end

  logic drv_en;
  assign drv_en = awake & (idle_cnt_reg == IW'(IDLE_CYC)) & ~thermal_fault;

  // oscillator-rate tick for the off-time counters
  localparam int DW = $clog2(bridge_pkg::OSC_DIV_CYC);
  logic [DW-1:0] div_reg;
  logic          osc_tick;
  assign osc_tick = (div_reg == DW'(bridge_pkg::OSC_DIV_CYC - 1));
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_reg <= '0;
    end else if (osc_tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // decay sequencer
  bridge_pkg::decay_state_t state_reg;
  logic [7:0]               off_cnt_reg;
  logic [7:0]               cnt_inc;
  assign cnt_inc = off_cnt_reg + 8'h01;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg   <= bridge_pkg::DECAY_ON;
      off_cnt_reg <= 8'h00;
    end else if (!drv_en) begin
      state_reg   <= bridge_pkg::DECAY_ON;
      off_cnt_reg <= 8'h00;
    end else begin
      case (state_reg)
        bridge_pkg::DECAY_ON: begin
          if (bridge_off_cmd || current_trip) begin
            state_reg   <= bridge_pkg::DECAY_FAST;
            off_cnt_reg <= 8'h00;
          end
        end
        bridge_pkg::DECAY_FAST: begin
          if (osc_tick) begin
            off_cnt_reg <= cnt_inc;
            // a fast portion longer than the off-time runs pure fast decay
            if (cnt_inc >= off_end) begin
              state_reg <= bridge_pkg::DECAY_ON;
            end else if (cnt_inc >= fast_end) begin
              state_reg <= bridge_pkg::DECAY_SLOW;
            end
          end
        end
        bridge_pkg::DECAY_SLOW: begin
          if (osc_tick) begin
            off_cnt_reg <= cnt_inc;
            if (cnt_inc >= off_end) begin
              state_reg <= bridge_pkg::DECAY_ON;
            end
          end
        end
        default: begin
          state_reg <= bridge_pkg::DECAY_ON;
        end
      endcase
    end
  end

  // rectifier cut-off latch, cleared at each off-time start
  logic in_off;
  logic cut_event;
  logic cut_reg;
  assign in_off    = (state_reg != bridge_pkg::DECAY_ON);
  assign cut_event = in_off & (((mode == bridge_pkg::RECT_ACTIVE) & zero_current) |
                               ((mode == bridge_pkg::RECT_PASSIVE) & reverse_limit));
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cut_reg <= 1'b0;
    end else if (!in_off) begin
      cut_reg <= 1'b0;
    end else if (cut_event) begin
      cut_reg <= 1'b1;
    end
  end

  logic sync_mode;
  logic plain_mode;
  assign sync_mode  = (mode == bridge_pkg::RECT_ACTIVE) | (mode == bridge_pkg::RECT_PASSIVE);
  // the reserved code is treated as disabled, the safest recirculation path
  assign plain_mode = ~sync_mode;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      control_word    <= bridge_pkg::SLEEP_WORD;
      drivers_enabled <= 1'b0;
      off_active      <= 1'b0;
      fast_decay      <= 1'b0;
      sync_rect_on    <= 1'b0;
      low_side_on     <= 1'b0;
    end else begin
      control_word    <= word_reg;
      drivers_enabled <= drv_en;
      off_active      <= drv_en & in_off;
      fast_decay      <= drv_en & (state_reg == bridge_pkg::DECAY_FAST);
      sync_rect_on    <= drv_en & in_off & sync_mode & ~cut_reg & ~cut_event;
      low_side_on     <= drv_en & plain_mode & (state_reg == bridge_pkg::DECAY_SLOW);
    end
  end
endmodule : bridge_rect_dev
`default_nettype wire

/* File: inc/bridge_pkg.sv */
package bridge_pkg;
  // serial control word layout
  localparam int          WORD_W       = 19;
  localparam int          OFF_LSB      = 3;
  localparam int          OFF_W        = 5;
  localparam int          OFF_TOP_BIT  = 7;
  localparam int          FAST_LSB     = 8;
  localparam int          FAST_W       = 4;
  localparam int          RECT_LSB     = 14;
  localparam int          IDLE_BIT     = 18;
  localparam logic [18:0] SLEEP_WORD   = 19'h00080;

  typedef enum logic [1:0] {
    RECT_ACTIVE   = 2'b00,
    RECT_DISABLED = 2'b01,
    RECT_PASSIVE  = 2'b10,
    RECT_RESERVED = 2'b11
  } rect_mode_t;

  typedef enum logic [1:0] {
    DECAY_ON   = 2'b00,
    DECAY_FAST = 2'b01,
    DECAY_SLOW = 2'b10
  } decay_state_t;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_LEAD  = 3'b001,
    TX_LOW   = 3'b010,
    TX_HIGH  = 3'b011,
    TX_TRAIL = 3'b100
  } tx_state_t;

  // timing
  localparam int CLK_MHZ          = 100;
  localparam int REF_PERIOD_NS    = 10;
  localparam int OSC_KHZ          = 4000;
  localparam int OSC_DIV_CYC      = CLK_MHZ * 1000 / OSC_KHZ;
  localparam int SLEEP_SETUP_US   = 50;
  localparam int SLEEP_SETUP_CYC  = SLEEP_SETUP_US * CLK_MHZ;
  localparam int IDLE_RELEASE_US  = 1000;
  localparam int IDLE_RELEASE_CYC = IDLE_RELEASE_US * CLK_MHZ;
  localparam int LINK_STEP_NS     = 120;
  localparam int LINK_STEP_CYC    = (LINK_STEP_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

  // host controller registers
  localparam logic [4:0] REG_DATA   = 5'h00;
  localparam logic [4:0] REG_CTRL   = 5'h04;
  localparam logic [4:0] REG_STATUS = 5'h08;
  localparam logic [4:0] REG_MASK   = 5'h0c;
  localparam logic [4:0] REG_STATE  = 5'h10;
  localparam int         EV_DONE    = 0;
  localparam int         EV_WAKE    = 1;
  localparam int         EV_W       = 2;
endpackage : bridge_pkg

/* File: inc/bridge_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface bridge_link_if;
  logic sclk;
  logic sdata;
  logic strobe_n;
  logic sleep_n;
  modport dev  (input sclk, input sdata, input strobe_n, input sleep_n);
  modport host (output sclk, output sdata, output strobe_n, output sleep_n);
endinterface : bridge_link_if
`default_nettype wire

/* File: rtl/bridge_serial_host.sv */
`timescale 1ns/1ps
`default_nettype none
module bridge_serial_host #(
  parameter int SLEEP_CYC = bridge_pkg::SLEEP_SETUP_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  bridge_link_if.host      link,
  input  wire logic [4:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  output logic             irq
);
  localparam int W  = bridge_pkg::WORD_W;
  localparam int SW = $clog2(SLEEP_CYC + 1);
  localparam int PW = $clog2(bridge_pkg::LINK_STEP_CYC + 1);

  logic [W-1:0]                word_reg;
  logic                        sleep_reg;
  logic [bridge_pkg::EV_W-1:0] status_reg;
  logic [bridge_pkg::EV_W-1:0] mask_reg;
  logic [SW-1:0]               wake_cnt_reg;
  logic                        start_reg;
  bridge_pkg::tx_state_t       state_reg;
  logic [PW-1:0]               step_reg;
  logic [4:0]                  bit_reg;
  logic [W-1:0]                tx_reg;
  logic                        done_ev;
  logic                        wake_ev;
  logic                        ready;
  logic                        step_end;

  assign ready    = sleep_reg & (wake_cnt_reg == SW'(SLEEP_CYC));
  assign wake_ev  = sleep_reg & (wake_cnt_reg == SW'(SLEEP_CYC - 1));
  assign step_end = (step_reg == PW'(bridge_pkg::LINK_STEP_CYC - 1));

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      word_reg  <= '0;
      sleep_reg <= 1'b0;
      mask_reg  <= '0;
      start_reg <= 1'b0;
    end else begin
      if (wr && addr == bridge_pkg::REG_DATA) begin
        word_reg  <= wdata[W-1:0];
        start_reg <= 1'b1;
      end else if (state_reg != bridge_pkg::TX_IDLE) begin
        start_reg <= 1'b0;
      end
      if (wr && addr == bridge_pkg::REG_CTRL) begin
        sleep_reg <= wdata[0];
      end
      if (wr && addr == bridge_pkg::REG_MASK) begin
        mask_reg <= wdata[bridge_pkg::EV_W-1:0];
      end
    end
  end

  // a new event beats a write-one-to-clear in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_reg <= '0;
    end else begin
      for (int i = 0; i < bridge_pkg::EV_W; i++) begin
        if ((i == bridge_pkg::EV_DONE && done_ev) || (i == bridge_pkg::EV_WAKE && wake_ev)) begin
          status_reg[i] <= 1'b1;
        end else if (wr && addr == bridge_pkg::REG_STATUS && wdata[i]) begin
          status_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
      irq   <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
      if (!rd) begin
        rdata <= 32'h0000_0000;
      end else if (addr == bridge_pkg::REG_DATA) begin
        rdata <= {{(32 - W){1'b0}}, word_reg};
      end else if (addr == bridge_pkg::REG_CTRL) begin
        rdata <= {31'h0000_0000, sleep_reg};
      end else if (addr == bridge_pkg::REG_STATUS) begin
        rdata <= {30'h0000_0000, status_reg};
      end else if (addr == bridge_pkg::REG_MASK) begin
        rdata <= {30'h0000_0000, mask_reg};
      end else if (addr == bridge_pkg::REG_STATE) begin
        rdata <= {29'h0000_0000, ready, start_reg, state_reg != bridge_pkg::TX_IDLE};
      end else begin
        rdata <= 32'h0000_0000;
      end
    end
  end

  // setup interval after sleep release
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wake_cnt_reg <= '0;
    end else if (!sleep_reg) begin
      wake_cnt_reg <= '0;
    end else if (!ready) begin
      wake_cnt_reg <= wake_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= bridge_pkg::TX_IDLE;
      step_reg  <= '0;
      bit_reg   <= 5'h00;
      tx_reg    <= '0;
      done_ev   <= 1'b0;
    end else begin
      done_ev  <= 1'b0;
      step_reg <= step_end ? '0 : step_reg + 1'b1;
      case (state_reg)
        bridge_pkg::TX_IDLE: begin
          step_reg <= '0;
          if (start_reg && ready) begin
            state_reg <= bridge_pkg::TX_LEAD;
            tx_reg    <= word_reg;
            bit_reg   <= 5'h00;
          end
        end
        bridge_pkg::TX_LEAD: begin
          if (step_end) begin
            state_reg <= bridge_pkg::TX_LOW;
          end
        end
        bridge_pkg::TX_LOW: begin
          if (step_end) begin
            state_reg <= bridge_pkg::TX_HIGH;
          end
        end
        bridge_pkg::TX_HIGH: begin
          if (step_end) begin
            tx_reg  <= {tx_reg[W-2:0], 1'b0};
            bit_reg <= bit_reg + 5'h01;
            state_reg <= (bit_reg == 5'(W - 1)) ? bridge_pkg::TX_TRAIL : bridge_pkg::TX_LOW;
          end
        end
        bridge_pkg::TX_TRAIL: begin
          if (step_end) begin
            state_reg <= bridge_pkg::TX_IDLE;
            done_ev   <= 1'b1;
          end
        end
        default: begin
          state_reg <= bridge_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // pins straight from flops; strobe stays high whenever no word is in flight
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link.sclk     <= 1'b0;
      link.sdata    <= 1'b0;
      link.strobe_n <= 1'b1;
      link.sleep_n  <= 1'b0;
    end else begin
      link.sleep_n  <= sleep_reg;
      link.strobe_n <= (state_reg == bridge_pkg::TX_IDLE) | (state_reg == bridge_pkg::TX_TRAIL && step_end);
      link.sclk     <= (state_reg == bridge_pkg::TX_HIGH) & ~step_end;
      link.sdata    <= tx_reg[W-1];
    end
  end
endmodule : bridge_serial_host
`default_nettype wire

/* File: sim/bridge_link_props.sv */
`timescale 1ns/1ps
`default_nettype none
module bridge_link_props #(
  parameter int SLEEP_CYC = bridge_pkg::SLEEP_SETUP_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic strobe_n,
  input wire logic sleep_n
);
  int   wake_cnt;
  int   bit_cnt;
  logic sclk_q;

  default clocking dclk @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // restarts on every sleep so a short wake pulse cannot hide an early clock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wake_cnt <= 0;
    end else if (!sleep_n) begin
      wake_cnt <= 0;
    end else if (wake_cnt < SLEEP_CYC) begin
      wake_cnt <= wake_cnt + 1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bit_cnt <= 0;
    end else if (strobe_n) begin
      bit_cnt <= 0;
    end else if (sclk && !sclk_q) begin
      bit_cnt <= bit_cnt + 1;
    end
  end

  sequence no_clk_rise_11;
    (!$rose(sclk)) [*8] ##1 (!$rose(sclk)) [*3];
  endsequence

  sequence strobe_low_12;
    (!strobe_n) [*8] ##1 (!strobe_n) [*4];
  endsequence

  chk_idle_strobe_high: assert property (!sleep_n |-> strobe_n)
    else $error("strobe low while asleep");
  chk_clk_in_frame: assert property ($rose(sclk) |-> !strobe_n)
    else $error("clock rise outside a frame");
  chk_data_setup_hold: assert property ($rose(sclk) |-> (sdata == $past(sdata, 4)) ##1 $stable(sdata))
    else $error("data moved around clock rise");
  chk_clk_high_width: assert property ($rose(sclk) |-> sclk [*4])
    else $error("clock high too short");
  chk_clk_low_width: assert property ($fell(sclk) |-> (!sclk) [*4])
    else $error("clock low too short");
  chk_strobe_width: assert property ($fell(strobe_n) |-> strobe_low_12)
    else $error("strobe pulse too short");
  chk_strobe_setup: assert property ($fell(strobe_n) |-> no_clk_rise_11)
    else $error("clock rise too soon after strobe");
  chk_strobe_after_clk: assert property ($rose(sclk) |-> (!$rose(strobe_n)) [*5])
    else $error("strobe rise too soon after clock");
  chk_sleep_setup: assert property ($rose(sclk) |-> wake_cnt >= SLEEP_CYC)
    else $error("clock too soon after wake");
  chk_word_length: assert property ($rose(strobe_n) |-> bit_cnt == bridge_pkg::WORD_W)
    else $error("frame bit count wrong");
endmodule : bridge_link_props
`default_nettype wire

/* File: sim/test_bridge_rectifier_serial_control.sv */
`timescale 1ns/1ps
`default_nettype none
module test_bridge_rectifier_serial_control;
  localparam int IDLE_N  = 50;
  localparam int SLEEP_N = 20;
  localparam int LIMIT   = 40000;
  typedef struct packed {
    logic [18:0] word;
    logic        sync_fast;
    logic        sync_zero;
    logic        low_slow;
  } row_t;
  // rows: active, disabled, passive, reserved (handled as disabled)
  row_t rows [4] = '{
    '{19'h40008, 1'b1, 1'b0, 1'b0},
    '{19'h44008, 1'b0, 1'b0, 1'b1},
    '{19'h48008, 1'b1, 1'b1, 1'b0},
    '{19'h4c008, 1'b0, 1'b0, 1'b1}};
  logic        ref_clk;
  logic        rst;
  logic        bridge_off_cmd, current_trip, zero_current, reverse_limit, thermal_fault;
  logic [4:0]  addr;
  logic [31:0] wdata;
  logic        wr, rd;
  logic [31:0] rdata;
  logic        irq;
  logic [18:0] control_word;
  logic        drivers_enabled, off_active, fast_decay, sync_rect_on, low_side_on;
  logic [31:0] mask_val;
  int          mismatches;
  int          tests_run;
  int          cycles;

  bridge_link_if link ();
  bridge_serial_host #(.SLEEP_CYC(SLEEP_N)) bridge_serial_host_i (.ref_clk(ref_clk), .rst(rst), .link(link),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  bridge_rect_dev #(.IDLE_CYC(IDLE_N)) bridge_rect_dev_i (.ref_clk(ref_clk), .rst(rst), .link(link),
    .bridge_off_cmd(bridge_off_cmd), .current_trip(current_trip), .zero_current(zero_current),
    .reverse_limit(reverse_limit), .thermal_fault(thermal_fault), .control_word(control_word),
    .drivers_enabled(drivers_enabled), .off_active(off_active), .fast_decay(fast_decay),
    .sync_rect_on(sync_rect_on), .low_side_on(low_side_on));
  bridge_link_props #(.SLEEP_CYC(SLEEP_N)) props_i (.ref_clk(ref_clk), .rst(rst), .sclk(link.sclk),
    .sdata(link.sdata), .strobe_n(link.strobe_n), .sleep_n(link.sleep_n));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      $display("wrong value at %0t: run did not finish", $time);
      final_report();
    end
  end

  task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_vec

  task automatic chk_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic wait_status(input int b);
    logic [31:0] d;
    d = '0;
    for (int n = 0; n < 400 && d[b] !== 1'b1; n++) begin
      rd_reg(bridge_pkg::REG_STATUS, d);
    end
    chk_bit(d[b], 1'b1, "status event");
  endtask : wait_status

  task automatic wake;
    wr_reg(bridge_pkg::REG_CTRL, 32'h00000001);
    wait_status(bridge_pkg::EV_WAKE);
    wr_reg(bridge_pkg::REG_STATUS, 32'h00000002);
  endtask : wake

  task automatic send_word(input logic [18:0] w);
    wr_reg(bridge_pkg::REG_DATA, {13'h0000, w});
    wait_status(bridge_pkg::EV_DONE);
    #1;
    chk_bit(irq, mask_val[0], "irq against mask");
    wr_reg(bridge_pkg::REG_STATUS, 32'h00000001);
    repeat (8) @(posedge ref_clk);
    #1;
    chk_bit(irq, 1'b0, "irq after clear");
    chk_vec({13'h0000, control_word}, {13'h0000, w}, "loaded word");
  endtask : send_word

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle

  initial begin
    logic [31:0] d;
    rst = 1'b1;
    {bridge_off_cmd, current_trip, zero_current, reverse_limit, thermal_fault, wr, rd} = '0;
    addr = '0;
    wdata = '0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk_vec({13'h0000, control_word}, {13'h0000, bridge_pkg::SLEEP_WORD}, "reset word");
    chk_bit(link.strobe_n, 1'b1, "strobe idle");
    chk_bit(drivers_enabled, 1'b0, "drivers at reset");
    mask_val = 32'h00000003;
    wr_reg(bridge_pkg::REG_MASK, mask_val);
    wake();
    foreach (rows[i]) begin
      send_word(rows[i].word);
      settle(IDLE_N + 20);
      chk_bit(drivers_enabled, 1'b1, "drivers on");
      @(posedge ref_clk);
      if (i % 2 == 0) bridge_off_cmd <= 1'b1;
      else current_trip <= 1'b1;
      @(posedge ref_clk);
      bridge_off_cmd <= 1'b0;
      current_trip <= 1'b0;
      settle(3);
      chk_bit(off_active, 1'b1, "off-time started");
      chk_bit(fast_decay, 1'b1, "fast part first");
      chk_bit(sync_rect_on, rows[i].sync_fast, "rectifier in fast");
      chk_bit(low_side_on, 1'b0, "low side in fast");
      @(posedge ref_clk);
      zero_current <= 1'b1;
      settle(3);
      chk_bit(sync_rect_on, rows[i].sync_zero, "rectifier at zero");
      @(posedge ref_clk);
      reverse_limit <= 1'b1;
      settle(3);
      chk_bit(sync_rect_on, 1'b0, "rectifier at limit");
      settle(220);
      chk_bit(fast_decay, 1'b0, "slow part");
      chk_bit(off_active, 1'b1, "off-time running");
      chk_bit(low_side_on, rows[i].low_slow, "low side in slow");
      for (int n = 0; n < 400 && off_active !== 1'b0; n++) settle(1);
      chk_bit(off_active, 1'b0, "off-time ends");
      @(posedge ref_clk);
      zero_current <= 1'b0;
      reverse_limit <= 1'b0;
    end
    @(posedge ref_clk);
    thermal_fault <= 1'b1;
    settle(4);
    chk_bit(drivers_enabled, 1'b0, "drivers in fault");
    @(posedge ref_clk);
    thermal_fault <= 1'b0;
    settle(IDLE_N + 20);
    chk_bit(drivers_enabled, 1'b1, "drivers after fault");
    send_word(19'h08008);
    chk_bit(drivers_enabled, 1'b0, "idle bit clear");
    mask_val = 32'h00000002;
    wr_reg(bridge_pkg::REG_MASK, mask_val);
    rd_reg(bridge_pkg::REG_MASK, d);
    chk_vec(d, mask_val, "mask readback");
    rd_reg(5'h1c, d);
    chk_vec(d, 32'h00000000, "unmapped read");
    rd_reg(bridge_pkg::REG_STATE, d);
    chk_vec(d, 32'h00000004, "state idle and ready");
    rd_reg(bridge_pkg::REG_CTRL, d);
    chk_vec(d, 32'h00000001, "ctrl readback");
    rd_reg(bridge_pkg::REG_DATA, d);
    chk_vec(d, 32'h00008008, "data readback");
    send_word(19'h40008);
    chk_bit(drivers_enabled, 1'b0, "before idle delay");
    settle(IDLE_N + 20);
    chk_bit(drivers_enabled, 1'b1, "after idle delay");
    wr_reg(bridge_pkg::REG_CTRL, 32'h00000000);
    settle(8);
    chk_bit(link.sleep_n, 1'b0, "sleep pin");
    chk_vec({13'h0000, control_word}, {13'h0000, bridge_pkg::SLEEP_WORD}, "sleep word");
    chk_bit(drivers_enabled, 1'b0, "drivers asleep");
    wake();
    send_word(19'h48008);
    final_report();
  end
endmodule : test_bridge_rectifier_serial_control
`default_nettype wire
